// [rtl/hpmx_pkg.sv]
// Package for the headphone output mix control register bank.
// Assumes a byte-wide register port with one-cycle read latency.
package hpmx_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LC_FROM_RCONV1_OFS  = 8'h39;
  localparam logic [7:0] LC_LEVEL_OFS        = 8'h3a;
  localparam logic [7:0] RHP_FROM_LLINE2_OFS = 8'h3b;
  localparam logic [7:0] RHP_FROM_LPRE_OFS   = 8'h3c;
  localparam logic [7:0] RHP_FROM_LCONV1_OFS = 8'h3d;
  localparam logic [7:0] RHP_FROM_RLINE2_OFS = 8'h3e;
  localparam logic [7:0] RHP_FROM_RPRE_OFS   = 8'h3f;
  localparam logic [7:0] RHP_FROM_RCONV1_OFS = 8'h40;
  localparam logic [7:0] RHP_LEVEL_OFS       = 8'h41;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ROUTE_BIT     = 7;
  localparam int         VOL_MSB       = 6;
  localparam int         LVL_MSB       = 7;
  localparam int         LVL_LSB       = 4;
  localparam int         UNMUTE_BIT    = 3;
  localparam int         PD_HIZ_BIT    = 2;
  localparam int         PENDING_BIT   = 1;
  localparam int         POWER_BIT     = 0;
  localparam logic [7:0] ROUTE_RESET   = 8'h00;
  localparam logic [7:0] LEVEL_RESET   = 8'h06;
  localparam logic [3:0] LVL_MAX_CODE  = 4'h9;
  localparam logic [6:0] VOL_RESET     = 7'h00;

  // ----------------------------------------------------------------
  // Timing: gain ramp step time and its cycle count at 100 MHz.
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ       = 100;
  localparam int         STEP_NS       = 1000;
  localparam int         STEP_CYCLES   = (STEP_NS * CLK_MHZ) / 1000;

  // One source path: route enable and volume code.
  typedef struct packed {
    logic       route_en;
    logic [6:0] volume;
  } hpmx_path_s;

  // Driver level control as seen by the analog side.
  typedef struct packed {
    logic [3:0] level;
    logic       unmute;
    logic       pd_hiz;
    logic       power_up;
  } hpmx_drv_s;

  typedef enum logic [1:0] {
    ST_SETTLED = 2'b01,
    ST_RAMPING = 2'b10
  } hpmx_ramp_e;

endpackage

// [rtl/hpmx_regs.sv]
// Register bank for the left common and right headphone driver mixers.
// Assumes a synchronous register port on clk; analog side reads outputs.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module hpmx_regs
  import hpmx_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic      [7:0]       reg_rdata,
  // Left common headphone driver controls
  output hpmx_path_s            lc_from_right_converter_one,
  output hpmx_drv_s             lc_drv,
  // Right headphone driver controls
  output hpmx_path_s            rhp_from_line_two_left,
  output hpmx_path_s            rhp_from_left_preamp,
  output hpmx_path_s            rhp_from_left_converter_one,
  output hpmx_path_s            rhp_from_line_two_right,
  output hpmx_path_s            rhp_from_right_preamp,
  output hpmx_path_s            rhp_from_right_converter_one,
  output hpmx_drv_s             rhp_drv
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] route_reg [0:6];
  logic [7:0] lc_level_reg;
  logic [7:0] rhp_level_reg;
  logic       lc_pending_reg;
  logic       rhp_pending_reg;

  // Index 0 is the left common path, 1..6 the right driver paths.
  function automatic logic [2:0] route_index(input logic [7:0] a);
    logic [2:0] idx;
    idx = 3'h7;
    unique case (a)
      LC_FROM_RCONV1_OFS:  idx = 3'h0;
      RHP_FROM_LLINE2_OFS: idx = 3'h1;
      RHP_FROM_LPRE_OFS:   idx = 3'h2;
      RHP_FROM_LCONV1_OFS: idx = 3'h3;
      RHP_FROM_RLINE2_OFS: idx = 3'h4;
      RHP_FROM_RPRE_OFS:   idx = 3'h5;
      RHP_FROM_RCONV1_OFS: idx = 3'h6;
      default:             idx = 3'h7;
    endcase
    return idx;
  endfunction

  logic [2:0] wr_idx;
  assign wr_idx = route_index(reg_addr);

  // ----------------------------------------------------------------
  // Routing registers
  // ----------------------------------------------------------------
  // route and volume store
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (reset)
        route_reg[i] <= ROUTE_RESET;
      else if (reg_write && wr_idx == 3'(i))
        route_reg[i] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Level control registers
  // ----------------------------------------------------------------
  // Bit 1 is never stored from the bus; it reads the pending flag.
  // writable fields
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // Bit 1 of the reset value is carried by the pending flag, not stored here.
      lc_level_reg  <= LEVEL_RESET & ~(8'h01 << PENDING_BIT);
      rhp_level_reg <= LEVEL_RESET & ~(8'h01 << PENDING_BIT);
    end
    else if (reg_write)
    begin
      if (reg_addr == LC_LEVEL_OFS)
        lc_level_reg <= reg_wdata & ~(8'h01 << PENDING_BIT);
      if (reg_addr == RHP_LEVEL_OFS)
        rhp_level_reg <= reg_wdata & ~(8'h01 << PENDING_BIT);
    end
  end

  // ----------------------------------------------------------------
  // Gain settling
  // ----------------------------------------------------------------
  // A write that touches a gain of the driver sets the flag for one step;
  // the outputs take the new gain one cycle after the register, whatever the flag.
  logic [15:0] lc_cnt_reg;
  logic [15:0] rhp_cnt_reg;
  logic        lc_gain_wr;
  logic        rhp_gain_wr;
  assign lc_gain_wr  = reg_write && (reg_addr == LC_LEVEL_OFS || wr_idx == 3'h0);
  assign rhp_gain_wr = reg_write && (reg_addr == RHP_LEVEL_OFS ||
                                     (wr_idx != 3'h0 && wr_idx != 3'h7));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lc_pending_reg  <= 1'b1;
      rhp_pending_reg <= 1'b1;
      lc_cnt_reg      <= 16'(STEP_CYCLES);
      rhp_cnt_reg     <= 16'(STEP_CYCLES);
    end
    else
    begin
      if (lc_gain_wr)
      begin
        lc_pending_reg <= 1'b1;
        lc_cnt_reg     <= 16'(STEP_CYCLES);
      end
      else if (lc_cnt_reg != 16'h0000)
        lc_cnt_reg <= lc_cnt_reg - 16'h0001;
      else
        lc_pending_reg <= 1'b0;
      if (rhp_gain_wr)
      begin
        rhp_pending_reg <= 1'b1;
        rhp_cnt_reg     <= 16'(STEP_CYCLES);
      end
      else if (rhp_cnt_reg != 16'h0000)
        rhp_cnt_reg <= rhp_cnt_reg - 16'h0001;
      else
        rhp_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (route_index(reg_addr) != 3'h7)
      rd_mux = route_reg[route_index(reg_addr)];
    else if (reg_addr == LC_LEVEL_OFS)
      rd_mux = lc_level_reg | {6'h00, lc_pending_reg, 1'b0};
    else if (reg_addr == RHP_LEVEL_OFS)
      rd_mux = rhp_level_reg | {6'h00, rhp_pending_reg, 1'b0};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lc_from_right_converter_one  <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_line_two_left       <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_left_preamp         <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_left_converter_one  <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_line_two_right      <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_right_preamp        <= hpmx_path_s'(ROUTE_RESET);
      rhp_from_right_converter_one <= hpmx_path_s'(ROUTE_RESET);
      lc_drv                       <= '{4'h0, 1'b0, 1'b1, 1'b0};
      rhp_drv                      <= '{4'h0, 1'b0, 1'b1, 1'b0};
    end
    else
    begin
      lc_from_right_converter_one  <= route_reg[0];
      rhp_from_line_two_left       <= route_reg[1];
      rhp_from_left_preamp         <= route_reg[2];
      rhp_from_left_converter_one  <= route_reg[3];
      rhp_from_line_two_right      <= route_reg[4];
      rhp_from_right_preamp        <= route_reg[5];
      rhp_from_right_converter_one <= route_reg[6];
      lc_drv  <= '{lc_level_reg[LVL_MSB:LVL_LSB], lc_level_reg[UNMUTE_BIT],
                   lc_level_reg[PD_HIZ_BIT], lc_level_reg[POWER_BIT]};
      rhp_drv <= '{rhp_level_reg[LVL_MSB:LVL_LSB], rhp_level_reg[UNMUTE_BIT],
                   rhp_level_reg[PD_HIZ_BIT], rhp_level_reg[POWER_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_lc_route_bit: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == LC_FROM_RCONV1_OFS
    |=> ##1 lc_from_right_converter_one.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("left common route bit not applied");

  chk_vol_readback: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_LPRE_OFS ##1 reg_read && reg_addr == RHP_FROM_LPRE_OFS
    |=> reg_rdata[VOL_MSB:0] == $past(reg_wdata[VOL_MSB:0], 2))
    else $error("volume code readback mismatch");

  chk_level_out: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_LEVEL_OFS
    |=> ##1 rhp_drv.level == $past(reg_wdata[LVL_MSB:LVL_LSB], 2))
    else $error("right level code not applied");

  chk_reserved_lvl: assert property (@(posedge clk) disable iff (reset)
    (lc_drv.level <= LVL_MAX_CODE) && (rhp_drv.level <= LVL_MAX_CODE))
    else $error("reserved level code reached a driver");

  chk_mute_out: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == LC_LEVEL_OFS
    |=> ##1 lc_drv.unmute == $past(reg_wdata[UNMUTE_BIT], 2))
    else $error("mute bit not applied");

  chk_hiz_out: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_LEVEL_OFS
    |=> ##1 rhp_drv.pd_hiz == $past(reg_wdata[PD_HIZ_BIT], 2))
    else $error("power-down drive bit not applied");

  chk_pending_set: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_RPRE_OFS ##1 reg_read && reg_addr == RHP_LEVEL_OFS
    |=> reg_rdata[PENDING_BIT])
    else $error("pending flag not raised after gain write");

  chk_power_out: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == LC_LEVEL_OFS
    |=> ##1 lc_drv.power_up == $past(reg_wdata[POWER_BIT], 2))
    else $error("power bit not applied");

  chk_rhp_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_LCONV1_OFS
    |=> ##1 rhp_from_left_converter_one == $past(reg_wdata, 2))
    else $error("right route from left converter not applied");

  chk_ro_flag: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == LC_LEVEL_OFS |=> lc_level_reg[PENDING_BIT] == 1'b0)
    else $error("read-only flag stored from bus");

  chk_lline2_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_LLINE2_OFS
    |=> ##1 rhp_from_line_two_left.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("right route from left line two not applied");

  chk_lpre_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_LPRE_OFS
    |=> ##1 rhp_from_left_preamp.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("right route from left preamp not applied");

  chk_rline2_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_RLINE2_OFS
    |=> ##1 rhp_from_line_two_right.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("right route from right line two not applied");

  chk_rpre_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_RPRE_OFS
    |=> ##1 rhp_from_right_preamp.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("right route from right preamp not applied");

  chk_rconv1_route: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == RHP_FROM_RCONV1_OFS
    |=> ##1 rhp_from_right_converter_one.route_en == $past(reg_wdata[ROUTE_BIT], 2))
    else $error("right route from right converter not applied");

  chk_lc_settled: assert property (@(posedge clk) disable iff (reset)
    !lc_gain_wr && lc_cnt_reg == 16'h0000
    |=> !lc_pending_reg)
    else $error("left common pending flag not cleared");

  chk_rhp_settled: assert property (@(posedge clk) disable iff (reset)
    !rhp_gain_wr && rhp_cnt_reg == 16'h0000
    |=> !rhp_pending_reg)
    else $error("right pending flag not cleared");

endmodule

// [sim/hpmx_regs_tb.sv]
// Self-checking bench for the headphone mix control register bank.
// Assumes one 100 MHz clock, a synchronous reset and the byte register port.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module hpmx_regs_tb
  import hpmx_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  hpmx_path_s path_out [0:6];
  hpmx_drv_s  lc_drv;
  hpmx_drv_s  rhp_drv;
  int         mismatches = 0;
  int         checked    = 0;
  logic [7:0] route_ofs [0:6] = '{LC_FROM_RCONV1_OFS, RHP_FROM_LLINE2_OFS, RHP_FROM_LPRE_OFS,
                                  RHP_FROM_LCONV1_OFS, RHP_FROM_RLINE2_OFS, RHP_FROM_RPRE_OFS,
                                  RHP_FROM_RCONV1_OFS};

  hpmx_regs hpmx_regs_i (
    .clk                          (clk),
    .reset                        (reset),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_write                    (reg_write),
    .reg_read                     (reg_read),
    .reg_rdata                    (reg_rdata),
    .lc_from_right_converter_one  (path_out[0]),
    .lc_drv                       (lc_drv),
    .rhp_from_line_two_left       (path_out[1]),
    .rhp_from_left_preamp         (path_out[2]),
    .rhp_from_left_converter_one  (path_out[3]),
    .rhp_from_line_two_right      (path_out[4]),
    .rhp_from_right_preamp        (path_out[5]),
    .rhp_from_right_converter_one (path_out[6]),
    .rhp_drv                      (rhp_drv)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Read data is sampled just after the taking edge, its only valid cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  // Write then read with no idle cycle between the two strobes.
  task automatic wr_rd_chk(input logic [7:0] wa, input logic [7:0] wd,
                           input logic [7:0] ra, input logic [7:0] exp);
    @(posedge clk);
    reg_addr  <= wa;
    reg_wdata <= wd;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    reg_addr  <= ra;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_check;
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    for (int i = 0; i < 7; i++)
    begin
      `CHK(path_out[i], 8'h00)
      rd_chk(route_ofs[i], 8'h00);
    end
    `CHK(lc_drv, 7'h02)
    `CHK(rhp_drv, 7'h02)
    rd_chk(LC_LEVEL_OFS, 8'h06);
    rd_chk(RHP_LEVEL_OFS, 8'h06);
    repeat (STEP_CYCLES + 10) @(posedge clk);
    rd_chk(LC_LEVEL_OFS, 8'h04);
    rd_chk(RHP_LEVEL_OFS, 8'h04);
  endtask

  // Two passes with route on then off catch stuck or aliased bits.
  task automatic route_check;
    logic [7:0] v;
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 7; i++)
        wr(route_ofs[i], (p == 0) ? 8'(8'h80 + 8'h2a + i) : 8'(8'h7f - i));
      rd_chk(RHP_LEVEL_OFS, 8'h06);
      for (int i = 0; i < 7; i++)
      begin
        v = (p == 0) ? 8'(8'h80 + 8'h2a + i) : 8'(8'h7f - i);
        rd_chk(route_ofs[i], v);
        `CHK(path_out[i], v)
      end
      repeat (STEP_CYCLES + 10) @(posedge clk);
      rd_chk(RHP_LEVEL_OFS, 8'h04);
    end
  endtask

  // Only codes 0 to 9 are written; the upper six are reserved.
  task automatic level_check;
    logic [3:0] k;
    for (int j = 0; j < 10; j++)
    begin
      k = 4'(j);
      wr(LC_LEVEL_OFS, {k, k[0], ~k[0], 1'b1, k[1]});
      @(posedge clk);
      #1;
      `CHK(lc_drv, {k, k[0], ~k[0], k[1]})
      rd_chk(LC_LEVEL_OFS, {k, k[0], ~k[0], 1'b1, k[1]});
    end
    wr(RHP_LEVEL_OFS, 8'h9f);
    rd_chk(RHP_LEVEL_OFS, 8'h9f);
    repeat (STEP_CYCLES + 10) @(posedge clk);
    rd_chk(RHP_LEVEL_OFS, 8'h9d);
    `CHK(rhp_drv, 7'h4f)
    wr(RHP_LEVEL_OFS, 8'h00);
    rd_chk(RHP_LEVEL_OFS, 8'h02);
    `CHK(rhp_drv, 7'h00)
  endtask

  task automatic unmapped_check;
    wr(8'h42, 8'hff);
    wr(8'h00, 8'hff);
    rd_chk(8'h42, 8'h00);
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 8'h00)
    rd_chk(8'h00, 8'h00);
    rd_chk(LC_FROM_RCONV1_OFS, 8'h7f);
  endtask

  // Back-to-back strobes: the read sees a write taken one edge earlier.
  task automatic b2b_check;
    wr_rd_chk(RHP_FROM_LPRE_OFS, 8'hd5, RHP_FROM_LPRE_OFS, 8'hd5);
    wr_rd_chk(RHP_FROM_RPRE_OFS, 8'h33, RHP_LEVEL_OFS, 8'h02);
    wr_rd_chk(LC_LEVEL_OFS, 8'h00, LC_FROM_RCONV1_OFS, 8'h7f);
  endtask

  task automatic print_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    reset     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reset_check();
    route_check();
    level_check();
    unmapped_check();
    b2b_check();
    reset_check();
    print_verdict();
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
